// [dv/i2ccs_bus_model.sv]
// partner on the two-wire lines: a foreign slave or a foreign master
`timescale 1ns/100ps
module i2ccs_bus_model (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_b_o,
  output logic sda_oe_b_o
);
  // ****************************************
  // open-drain drivers, released means pulled high
  // ****************************************
  initial begin
    scl_oe_b_o = 1'b1;
    sda_oe_b_o = 1'b1;
  end
  // slave side: shift tx out, take 8 bits, then ack or sample the ninth
  // data moves 10 ns after the fall so the block never sees a false start or stop
  task automatic slv_xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx, output logic mack);
    for (int i = 7; i >= 0; i--) begin
      sda_oe_b_o = tx[i];
      @(posedge scl_i) rx[i] = sda_i;
      @(negedge scl_i);
      #10;
    end
    sda_oe_b_o = ~ack;
    @(posedge scl_i) mack = sda_i;
    @(negedge scl_i);
    #10 sda_oe_b_o = 1'b1;
  endtask
  // master side: 64 ns link clock, only inside frames
  task automatic mst_start();
    sda_oe_b_o = 1'b0;
    #32 scl_oe_b_o = 1'b0;
  endtask
  task automatic mst_byte(input logic [7:0] d, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_oe_b_o = (i == 0) ? 1'b1 : d[i-1];
      #16 scl_oe_b_o = 1'b1;
      wait (scl_i);
      ack = ~sda_i;
      #32 scl_oe_b_o = 1'b0;
      #16;
    end
  endtask
  task automatic mst_stop();
    sda_oe_b_o = 1'b0;
    #16 scl_oe_b_o = 1'b1;
    #32 sda_oe_b_o = 1'b1;
    #32;
  endtask
endmodule

// [dv/tb_top.sv]
// self-checking bench of the two-wire control and status block
`timescale 1ns/100ps
module tb_top import i2ccs_pkg::*; ;
  // ****************************************
  // stimulus, wires and reference state
  // ****************************************
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DW-1:0] rdata;
  i2ccs_line_s line_w;
  i2ccs_line_s line_o;
  i2ccs_line_s oe_b;
  logic m_scl;
  logic m_sda;
  int bad_count = 0;
  int tests_run = 0;
  logic [7:0] rxq[$];
  logic [DW-1:0] v;
  logic [7:0] own;
  logic [7:0] d;
  logic [7:0] got;
  logic [6:0] a7;
  logic ak;
  logic mk;
  always #2.5 clk_sys_i = ~clk_sys_i;
  // wired-and: any party pulling low wins over the pull-up
  assign line_w = '{scl: oe_b.scl & m_scl, sda: oe_b.sda & m_sda};
  i2ccs_top #(.QTR(4)) dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .line_i(line_w), .line_o(line_o), .line_oe_b_o(oe_b));
  i2ccs_bus_model m (.scl_i(line_w.scl), .sda_i(line_w.sda), .scl_oe_b_o(m_scl), .sda_oe_b_o(m_sda));
  // register port cycles
  task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] x);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [AW-1:0] a, output logic [DW-1:0] x);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 x = rdata;
  endtask
  task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_st(input string n, input logic [DW-1:0] msk, input logic [DW-1:0] e);
    rreg(ADDR_STAT, v);
    chk(n, e & msk, v & msk);
  endtask
  // bounded poll so a stuck sequence shows as a mismatch, not a hang
  task automatic wait_for(input logic [AW-1:0] a, input logic [DW-1:0] msk, input logic [DW-1:0] e);
    for (int i = 0; i < 3000; i++) begin
      rreg(a, v);
      if ((v & msk) === e) return;
    end
    chk("poll", e, v & msk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog well past the expected run length
  initial begin
    #300000;
    bad_count++;
    report_and_stop();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(25372));
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rreg(ADDR_CTRL, v);
    chk("ctrl_rst", CTRL_RST, v);
    chk_st("stat_rst", 16'hffff, 16'h0000);
    rreg(3'h7, v);
    chk("unmapped", 16'h0000, v);
    own = 8'($urandom_range(8, 119));
    wreg(ADDR_OWN, {9'h0, own[6:0]});
    rreg(ADDR_OWN, v);
    chk("own", {9'h0, own[6:0]}, v);
    // start refused while the partner holds data low
    m.sda_oe_b_o = 1'b0;
    wreg(ADDR_CTRL, 16'h1 << C_START);
    wait_for(ADDR_CTRL, 16'h1 << C_START, 16'h0);
    chk_st("coll", 16'h1 << S_COLL, 16'h1 << S_COLL);
    m.sda_oe_b_o = 1'b1;
    wreg(ADDR_STAT, 16'h0);
    chk_st("coll_clr", 16'h1 << S_COLL, 16'h0);
    wreg(ADDR_CTRL, 16'h1 << C_START);
    wait_for(ADDR_CTRL, 16'h1 << C_START, 16'h0);
    chk_st("start", 16'h18, 16'h08);
    // transmit: acked byte, then nacked byte, each with a refused second write
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      fork
        m.slv_xfer(8'hff, k == 0, got, mk);
      join_none
      wreg(ADDR_TXH, {8'h0, d});
      chk_st("txf", 16'h1 << S_TXF, 16'h1 << S_TXF);
      wreg(ADDR_TXH, {8'h0, ~d});
      chk_st("wcol", 16'h4080, 16'h4080);
      rreg(ADDR_TXH, v);
      chk("txh_kept", {8'h0, d}, v);
      wait_for(ADDR_STAT, 16'h4001, 16'h0);
      wait fork;
      chk("tx_byte", {8'h0, d}, {8'h0, got});
      chk_st("ackr", 16'h1 << S_ACKR, 16'(k) << S_ACKR);
      wreg(ADDR_STAT, 16'h0);
    end
    // receive one byte each, then acknowledge with both ack values
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      rxq.push_back(d);
      fork
        m.slv_xfer(d, 1'b0, got, mk);
      join_none
      wreg(ADDR_CTRL, 16'h1 << C_RCV);
      wait_for(ADDR_CTRL, 16'h1 << C_RCV, 16'h0);
      chk_st("rxf", 16'h1 << S_RXF, 16'h1 << S_RXF);
      rreg(ADDR_RXH, v);
      chk("rx_byte", {8'h0, rxq.pop_front()}, v);
      chk_st("rxf_clr", 16'h1 << S_RXF, 16'h0);
      wreg(ADDR_CTRL, 16'h1 << C_ACKGO | 16'(k) << C_ACKVAL);
      wait_for(ADDR_CTRL, 16'h1 << C_ACKGO, 16'h0);
      wait fork;
      chk("ack_bit", 16'(k), {15'h0, mk});
    end
    wreg(ADDR_CTRL, 16'h1 << C_RSTART);
    wait_for(ADDR_CTRL, 16'h1 << C_RSTART, 16'h0);
    chk_st("rstart", 16'h18, 16'h08);
    wreg(ADDR_CTRL, 16'h1 << C_STOP);
    wait_for(ADDR_CTRL, 16'h1 << C_STOP, 16'h0);
    chk_st("stop", 16'h18, 16'h10);
    // slave: own address then general call, two bytes so the second overflows
    for (int k = 0; k < 2; k++) begin
      a7 = k ? 7'h00 : own[6:0];
      m.mst_start();
      m.mst_byte({a7, 1'b0}, ak);
      chk("addr_ack", 16'h1, {15'h0, ak});
      chk_st("addr", 16'h22c, 16'(k) << S_GC | 16'h8);
      for (int j = 0; j < 2; j++) begin
        d = 8'($urandom);
        if (j == 0) rxq.push_back(d);
        m.mst_byte(d, ak);
      end
      chk_st("ovf", 16'h62, 16'h62);
      rreg(ADDR_RXH, v);
      chk("slv_rx", {8'h0, rxq.pop_front()}, v);
      m.mst_stop();
      chk_st("gc_clr", 16'h218, 16'h10);
      wreg(ADDR_STAT, 16'h0);
    end
    // ten-bit address with clock hold: slave keeps the clock low until released
    wreg(ADDR_OWN, 16'h200 | 16'(own));
    wreg(ADDR_CTRL, 16'h1 << C_TENBIT | 16'h1 << C_HOLD);
    m.mst_start();
    m.mst_byte(8'hf4, ak);
    m.mst_byte(own, mk);
    chk("ten_ack", 16'h3, {14'h0, ak, mk});
    chk_st("long", 16'h120, 16'h100);
    d = 8'($urandom);
    fork
      m.mst_byte(d, ak);
    join_none
    wait_for(ADDR_STAT, 16'h1 << S_RXF, 16'h1 << S_RXF);
    #200;
    chk("hold", 16'h0, {15'h0, oe_b.scl});
    wreg(ADDR_CTRL, 16'h1 << C_TENBIT | 16'h1 << C_HOLD | 16'h1 << C_REL);
    wait fork;
    chk("hold_ack", 16'h1, {15'h0, ak});
    rreg(ADDR_RXH, v);
    chk("long_rx", {8'h0, d}, v);
    m.mst_stop();
    chk_st("long_clr", 16'h1 << S_LONG, 16'h0);
    // read address: acknowledged, direction reported, then silence
    wreg(ADDR_CTRL, 16'h0);
    m.mst_start();
    m.mst_byte({own[6:0], 1'b1}, ak);
    chk("rd_ack", 16'h1, {15'h0, ak});
    chk_st("rw", 16'h4, 16'h4);
    m.mst_stop();
    // open drain: the driven level is always low
    chk("line_o", 16'h0, {14'h0, line_o});
    report_and_stop();
  end
endmodule

// [pkg/i2ccs_pkg.sv]
// shared constants, types and register map of the two-wire control and status block
package i2ccs_pkg;
  // ****************************************
  // register map (word index on the plain port)
  // ****************************************
  localparam int AW = 3;
  localparam int DW = 16;
  localparam logic [AW-1:0] ADDR_CTRL = 3'h0;
  localparam logic [AW-1:0] ADDR_STAT = 3'h1;
  localparam logic [AW-1:0] ADDR_TXH = 3'h2;
  localparam logic [AW-1:0] ADDR_RXH = 3'h3;
  localparam logic [AW-1:0] ADDR_OWN = 3'h4;
  // control fields
  localparam int C_START = 0;
  localparam int C_RSTART = 1;
  localparam int C_STOP = 2;
  localparam int C_RCV = 3;
  localparam int C_ACKGO = 4;
  localparam int C_ACKVAL = 5;
  localparam int C_HOLD = 6;
  localparam int C_TENBIT = 10;
  localparam int C_ALLADR = 11;
  localparam int C_REL = 12;
  // status fields
  localparam int S_TXF = 0;
  localparam int S_RXF = 1;
  localparam int S_RW = 2;
  localparam int S_STA = 3;
  localparam int S_STO = 4;
  localparam int S_DA = 5;
  localparam int S_OVF = 6;
  localparam int S_WCOL = 7;
  localparam int S_LONG = 8;
  localparam int S_GC = 9;
  localparam int S_COLL = 10;
  localparam int S_TXACT = 14;
  localparam int S_ACKR = 15;
  // reset values
  localparam logic [DW-1:0] CTRL_RST = 16'h0000;
  localparam logic [9:0] OWN_RST = 10'h000;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 5;
  localparam int BIT_NS = 2500;
  localparam int QTR_CYC = BIT_NS / (4 * CLK_NS);
  localparam logic [4:0] TEN_HDR = 5'h1e;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // ****************************************
  // types
  // ****************************************
  typedef enum {M_IDLE, M_START, M_RSTART, M_STOP, M_TX, M_RX, M_ACK} i2ccs_mst_e;
  typedef enum {SL_ADDR, SL_ADDR2, SL_DATA, SL_IGN} i2ccs_slv_e;
  typedef struct packed {
    logic scl;
    logic sda;
  } i2ccs_line_s;
endpackage

// [verilog/i2ccs_top.sv]
// two-wire bus controller: master sequences, slave receive and status flags
// What this block does
// (RULE1) slave holds clock low after received bytes only when clock_hold_enable set
// (RULE2) acknowledge sequence drives ack_value onto the data line
// (RULE3) ack_sequence_go runs one acknowledge bit, then self-clears
// (RULE4) master_receive_go receives one byte, clears after eighth bit
// (RULE5) stop_go makes a Stop, clears when done
// (RULE6) restart_go makes a Repeated Start, clears when done
// (RULE7) start_go makes a Start, clears when done
// (RULE8) software keeps accept_all_addresses low during master operations
// (RULE9) ack_result takes slave acknowledge level at end of each byte
// (RULE10) master_tx_active high from byte start to end of slave acknowledge
// (RULE11) status bits 13 to 11 read zero
// (RULE12) collision_flag set on master bus collision, cleared by software only
// (RULE13) general_call_seen set on general call match, cleared at Stop
// (RULE14) long_address_matched set on ten-bit second byte match, cleared at Stop
// (RULE15) transmit holding write while busy fails and sets tx_write_collision
// (RULE16) rx_overflow set when new byte arrives while holding register full
// (RULE17) data_not_address cleared on address match, set on data byte
// (RULE18) stop_seen set by Stop, cleared by Start or Repeated Start
// (RULE19) start_seen set by Start or Repeated Start, cleared by Stop
// (RULE20) read_not_write captured from address byte in slave mode
// (RULE21) rx_full set on holding register load, cleared on its read
// (RULE22) tx_full set on transmit holding write, cleared when byte sent
// (RULE23) software requests one master sequence at a time
`timescale 1ns/100ps
module i2ccs_top import i2ccs_pkg::*; #(
  parameter int QTR = QTR_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DW-1:0] rdata_o,
  input wire i2ccs_line_s line_i,
  output i2ccs_line_s line_o,
  output i2ccs_line_s line_oe_b_o
);
  // too long a quarter would stretch the assertion windows past their bound
  if (QTR < 2 || QTR > 248) begin : g_qtr_bad
    $error("QTR out of range");
  end

  // ****************************************
  // pin synchronisers and bus conditions
  // ****************************************
  i2ccs_line_s ln_m_q, ln_s_q, ln_d_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ln_m_q <= 2'h3;
      ln_s_q <= 2'h3;
      ln_d_q <= 2'h3;
    end else begin
      ln_m_q <= line_i;
      ln_s_q <= ln_m_q;
      ln_d_q <= ln_s_q;
    end
  end
  wire scl_s = ln_s_q.scl;
  wire sda_s = ln_s_q.sda;
  wire start_det = scl_s & ln_d_q.scl & ln_d_q.sda & ~sda_s;
  wire stop_det = scl_s & ln_d_q.scl & ~ln_d_q.sda & sda_s;
  wire scl_rise = scl_s & ~ln_d_q.scl;
  wire scl_fall = ~scl_s & ln_d_q.scl;

  // ****************************************
  // register decode
  // ****************************************
  wire wr_ctl = wr_i && addr_i == ADDR_CTRL;
  wire wr_stat = wr_i && addr_i == ADDR_STAT;
  wire wr_tx = wr_i && addr_i == ADDR_TXH;
  wire wr_own = wr_i && addr_i == ADDR_OWN;
  wire rd_rx = rd_i && addr_i == ADDR_RXH;

  // ****************************************
  // quarter-bit divider, sole source of master timing
  // ****************************************
  logic [15:0] div_q;
  logic tick_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q == 16'(QTR - 1);
      div_q <= (div_q == 16'(QTR - 1)) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // ****************************************
  // plain control bits
  // ****************************************
  logic ack_val_q, hold_en_q, ten_q, all_adr_q, rel_q;
  logic [9:0] own_q;
  logic hold_set;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_val_q <= CTRL_RST[C_ACKVAL];
      hold_en_q <= CTRL_RST[C_HOLD];
      ten_q <= CTRL_RST[C_TENBIT];
      all_adr_q <= CTRL_RST[C_ALLADR];
      rel_q <= CTRL_RST[C_REL];
      own_q <= OWN_RST;
    end else begin
      if (wr_ctl) begin
        ack_val_q <= wdata_i[C_ACKVAL];
        hold_en_q <= wdata_i[C_HOLD];
        ten_q <= wdata_i[C_TENBIT];
        all_adr_q <= wdata_i[C_ALLADR];
      end
      // a hold taken by the slave wins over a release written in the same cycle
      if (hold_set) begin
        rel_q <= 1'b0; // RULE1
      end else if (wr_ctl) begin
        rel_q <= wdata_i[C_REL];
      end
      if (wr_own) begin
        own_q <= wdata_i[9:0];
      end
    end
  end

  // ****************************************
  // master sequencer
  // ****************************************
  i2ccs_mst_e ms_q;
  logic [1:0] ph_q;
  logic [3:0] bc_q;
  logic [7:0] msh_q;
  logic go_st_q, go_rs_q, go_sp_q, go_rc_q, go_ak_q;
  logic m_scl_q, m_sda_q, mown_q, txact_q, txf_q, ackr_q, coll_ev_q, mrx_ld_q;
  logic [7:0] txh_q;
  wire go_any = go_st_q | go_rs_q | go_sp_q | go_rc_q | go_ak_q;
  wire m_busy = ms_q != M_IDLE || go_any;
  wire bit_st = ms_q == M_TX || ms_q == M_RX || ms_q == M_ACK;
  // waiting in phase 2 lets a slave stretch the clock
  wire adv = tick_q && !(ph_q == 2'h2 && !scl_s && (bit_st || ms_q == M_RSTART));
  wire last_ph = adv && ph_q == 2'h3;
  wire tx_go = wr_tx && !m_busy && mown_q;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ms_q <= M_IDLE;
      ph_q <= 2'h0;
      bc_q <= 4'h0;
      msh_q <= 8'h00;
      {go_st_q, go_rs_q, go_sp_q, go_rc_q, go_ak_q} <= 5'h00;
      {m_scl_q, m_sda_q, mown_q, txact_q, ackr_q, coll_ev_q, mrx_ld_q} <= 7'h00;
    end else begin
      coll_ev_q <= 1'b0;
      mrx_ld_q <= 1'b0;
      if (adv) begin
        ph_q <= ph_q + 2'h1;
      end
      case (ms_q)
        M_IDLE: begin
          ph_q <= 2'h0;
          bc_q <= 4'h0;
          // requests only land while idle and none pending, so hardware clears never race them
          if (wr_ctl && !go_any) begin
            go_st_q <= wdata_i[C_START];
            go_rs_q <= wdata_i[C_RSTART];
            go_sp_q <= wdata_i[C_STOP];
            go_rc_q <= wdata_i[C_RCV];
            go_ak_q <= wdata_i[C_ACKGO];
          end else if (go_st_q) begin
            ms_q <= M_START;
          end else if (go_rs_q) begin
            ms_q <= M_RSTART;
          end else if (go_sp_q) begin
            ms_q <= M_STOP;
          end else if (go_rc_q) begin
            ms_q <= M_RX;
          end else if (go_ak_q) begin
            ms_q <= M_ACK;
          end else if (tx_go) begin
            ms_q <= M_TX;
            msh_q <= wdata_i[7:0];
            txact_q <= 1'b1; // RULE10
          end
        end
        M_START: begin
          if (adv && ph_q == 2'h0 && !sda_s) begin
            // line already low: someone else owns the bus
            coll_ev_q <= 1'b1; // RULE12
            go_st_q <= 1'b0;
            ms_q <= M_IDLE;
          end else if (adv && ph_q == 2'h0) begin
            m_sda_q <= 1'b1;
          end else if (adv && ph_q == 2'h2) begin
            m_scl_q <= 1'b1;
          end else if (last_ph) begin
            go_st_q <= 1'b0; // RULE7
            mown_q <= 1'b1;
            ms_q <= M_IDLE;
          end
        end
        M_RSTART: begin
          if (adv && ph_q == 2'h0) begin
            m_sda_q <= 1'b0;
          end else if (adv && ph_q == 2'h1) begin
            m_scl_q <= 1'b0;
          end else if (adv && ph_q == 2'h2) begin
            m_sda_q <= 1'b1;
          end else if (last_ph) begin
            m_scl_q <= 1'b1;
            go_rs_q <= 1'b0; // RULE6
            ms_q <= M_IDLE;
          end
        end
        M_STOP: begin
          if (adv && ph_q == 2'h0) begin
            m_sda_q <= 1'b1;
          end else if (adv && ph_q == 2'h1) begin
            m_scl_q <= 1'b0;
          end else if (adv && ph_q == 2'h2) begin
            m_sda_q <= 1'b0;
          end else if (last_ph) begin
            go_sp_q <= 1'b0; // RULE5
            mown_q <= 1'b0;
            ms_q <= M_IDLE;
          end
        end
        default: begin
          // one bit per four phases: set data, raise clock, sample, lower clock
          if (adv && ph_q == 2'h0) begin
            if (ms_q == M_TX) begin
              m_sda_q <= bc_q != ACK_BIT && !msh_q[7];
            end else if (ms_q == M_ACK) begin
              m_sda_q <= !ack_val_q; // RULE2
            end else begin
              m_sda_q <= 1'b0;
            end
          end else if (adv && ph_q == 2'h1) begin
            m_scl_q <= 1'b0;
          end else if (adv && ph_q == 2'h2) begin
            if (ms_q == M_TX && bc_q != ACK_BIT && !m_sda_q && !sda_s) begin
              // released a one but read a zero: lost arbitration
              coll_ev_q <= 1'b1; // RULE12
              txact_q <= 1'b0;
              mown_q <= 1'b0;
              m_scl_q <= 1'b0;
              ms_q <= M_IDLE;
            end else if (ms_q == M_TX && bc_q == ACK_BIT) begin
              ackr_q <= sda_s; // RULE9
            end else if (ms_q == M_RX) begin
              msh_q <= {msh_q[6:0], sda_s};
            end
          end else if (last_ph) begin
            m_scl_q <= 1'b1;
            bc_q <= bc_q + 4'h1;
            if (ms_q == M_TX) begin
              msh_q <= {msh_q[6:0], 1'b0};
            end
            if (ms_q == M_TX && bc_q == ACK_BIT) begin
              txact_q <= 1'b0; // RULE10
              ms_q <= M_IDLE;
            end else if (ms_q == M_RX && bc_q == LAST_BIT) begin
              go_rc_q <= 1'b0; // RULE4
              mrx_ld_q <= 1'b1;
              ms_q <= M_IDLE;
            end else if (ms_q == M_ACK) begin
              m_sda_q <= 1'b0;
              go_ak_q <= 1'b0; // RULE3
              ms_q <= M_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // transmit holding register
  // ****************************************
  wire tx_done = ms_q == M_TX && last_ph && bc_q == ACK_BIT;
  logic s_act_q;
  wire busy = m_busy || s_act_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      txh_q <= 8'h00;
      txf_q <= 1'b0;
    end else begin
      if (wr_tx && !busy) begin
        txh_q <= wdata_i[7:0];
        txf_q <= 1'b1; // RULE22
      end else if (tx_done) begin
        txf_q <= 1'b0; // RULE22
      end
    end
  end

  // ****************************************
  // slave receiver
  // ****************************************
  i2ccs_slv_e sl_q;
  logic [3:0] sc_q;
  logic [7:0] ssh_q;
  logic s_sda_q, hold_q, gc_q, long_q, da_q, rw_q, srx_ld_q;
  logic rxf_q;
  wire s_arm = start_det && ms_q == M_IDLE && !mown_q;
  wire byte_end = s_act_q && scl_fall && sc_q == ACK_BIT;
  wire gc_hit = ssh_q == 8'h00;
  wire m7_hit = !ten_q && ssh_q[7:1] == own_q[6:0];
  wire ten_hit = ten_q && ssh_q[7:3] == TEN_HDR && ssh_q[2:1] == own_q[9:8] && !ssh_q[0];
  assign hold_set = byte_end && sl_q == SL_DATA && hold_en_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sl_q <= SL_IGN;
      sc_q <= 4'h0;
      ssh_q <= 8'h00;
      {s_act_q, s_sda_q, hold_q, gc_q, long_q, da_q, rw_q, srx_ld_q} <= 8'h00;
    end else begin
      srx_ld_q <= 1'b0;
      if (hold_set) begin
        hold_q <= 1'b1; // RULE1
      end else if (rel_q || !hold_en_q) begin
        hold_q <= 1'b0; // RULE1
      end
      if (stop_det) begin
        s_act_q <= 1'b0;
        s_sda_q <= 1'b0;
        gc_q <= 1'b0; // RULE13
        long_q <= 1'b0; // RULE14
        sl_q <= SL_IGN;
      end else if (s_arm) begin
        s_act_q <= 1'b1;
        sc_q <= 4'h0;
        sl_q <= SL_ADDR;
      end else if (s_act_q && scl_rise && sc_q != ACK_BIT + 4'h1) begin
        if (sc_q != ACK_BIT) begin
          ssh_q <= {ssh_q[6:0], sda_s};
        end
        sc_q <= sc_q + 4'h1;
      end else if (byte_end) begin
        case (sl_q)
          SL_ADDR: begin
            if (all_adr_q || gc_hit || m7_hit) begin
              s_sda_q <= 1'b1;
              da_q <= 1'b0; // RULE17
              rw_q <= ssh_q[0]; // RULE20
              gc_q <= gc_q | gc_hit; // RULE13
              // reads are not served here: the slave acknowledges and stays silent
              sl_q <= ssh_q[0] ? SL_IGN : SL_DATA;
            end else if (ten_hit) begin
              s_sda_q <= 1'b1;
              rw_q <= 1'b0; // RULE20
              sl_q <= SL_ADDR2;
            end else begin
              sl_q <= SL_IGN;
            end
          end
          SL_ADDR2: begin
            if (ssh_q == own_q[7:0]) begin
              s_sda_q <= 1'b1;
              long_q <= 1'b1; // RULE14
              da_q <= 1'b0; // RULE17
              sl_q <= SL_DATA;
            end else begin
              sl_q <= SL_IGN;
            end
          end
          SL_DATA: begin
            s_sda_q <= 1'b1;
            da_q <= 1'b1; // RULE17
            srx_ld_q <= 1'b1;
          end
          default: begin
            s_sda_q <= 1'b0;
          end
        endcase
      end else if (s_act_q && scl_fall && sc_q == ACK_BIT + 4'h1) begin
        s_sda_q <= 1'b0;
        sc_q <= 4'h0;
      end
    end
  end

  // ****************************************
  // receive holding register and sticky status
  // ****************************************
  logic [7:0] rxh_q;
  logic coll_q, wcol_q, ovf_q, sta_q, sto_q;
  wire rx_ld = mrx_ld_q | srx_ld_q;
  wire [7:0] rx_byte = mrx_ld_q ? msh_q : ssh_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rxh_q <= 8'h00;
      {rxf_q, coll_q, wcol_q, ovf_q, sta_q, sto_q} <= 6'h00;
    end else begin
      // an overflowing byte is dropped, the held byte survives
      if (rx_ld && !rxf_q) begin
        rxh_q <= rx_byte;
      end
      rxf_q <= rx_ld || (rxf_q && !rd_rx); // RULE21
      ovf_q <= (rx_ld && rxf_q) || (ovf_q && !(wr_stat && !wdata_i[S_OVF])); // RULE16
      wcol_q <= (wr_tx && busy) || (wcol_q && !(wr_stat && !wdata_i[S_WCOL])); // RULE15
      coll_q <= coll_ev_q || (coll_q && !(wr_stat && !wdata_i[S_COLL])); // RULE12
      if (start_det) begin
        sta_q <= 1'b1; // RULE19
        sto_q <= 1'b0; // RULE18
      end else if (stop_det) begin
        sta_q <= 1'b0; // RULE19
        sto_q <= 1'b1; // RULE18
      end
    end
  end

  // ****************************************
  // read mux and pin drive
  // ****************************************
  wire [DW-1:0] ctl_word = {3'h0, rel_q, all_adr_q, ten_q, 3'h0, hold_en_q, ack_val_q,
                            go_ak_q, go_rc_q, go_sp_q, go_rs_q, go_st_q};
  wire [DW-1:0] st_word = {ackr_q, txact_q, 3'h0, coll_q, gc_q, long_q, // RULE11
                           wcol_q, ovf_q, da_q, sto_q, sta_q, rw_q, rxf_q, txf_q};
  wire [DW-1:0] rd_mux = addr_i == ADDR_CTRL ? ctl_word :
                         addr_i == ADDR_STAT ? st_word :
                         addr_i == ADDR_TXH ? {8'h00, txh_q} :
                         addr_i == ADDR_RXH ? {8'h00, rxh_q} :
                         addr_i == ADDR_OWN ? {6'h00, own_q} : 16'h0000;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 16'h0000;
      line_o <= 2'h0;
      line_oe_b_o <= 2'h3;
    end else begin
      rdata_o <= rd_i ? rd_mux : 16'h0000;
      line_o <= 2'h0; // open drain: only ever pulls low
      line_oe_b_o <= {~(m_scl_q | hold_q), ~(m_sda_q | s_sda_q)};
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  localparam int SEQ_MAX = 4 * QTR + 8;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence seq_tx_busy_write;
    wr_tx && busy;
  endsequence
  sequence seq_start_req;
    ms_q == M_IDLE && go_st_q && !wr_ctl;
  endsequence
  AST_START_CLEARS: assert property (seq_start_req |-> ##[1:SEQ_MAX] !go_st_q) // RULE7
    else $error("start request did not self-clear");
  AST_STOP_CLEARS: assert property ($rose(ms_q == M_STOP) |-> ##[1:SEQ_MAX] !go_sp_q) // RULE5
    else $error("stop request did not self-clear");
  AST_ACK_LEVEL: assert property (ms_q == M_ACK && ph_q == 2'h2 |-> m_sda_q == !ack_val_q) // RULE2
    else $error("acknowledge level differs from ack value");
  AST_TX_ACTIVE: assert property (ms_q == M_TX |-> txact_q) // RULE10
    else $error("transmit active low during byte");
  AST_WCOL: assert property (seq_tx_busy_write |=> wcol_q && $stable(txh_q)) // RULE15
    else $error("busy write not refused");
  AST_RX_FULL: assert property (rx_ld |=> rxf_q) // RULE21
    else $error("receive full not set on load");
  AST_OVF: assert property (rx_ld && rxf_q |=> ovf_q && $stable(rxh_q)) // RULE16
    else $error("overflow not flagged");
  AST_STOP_SEEN: assert property (stop_det |=> sto_q && !sta_q && !gc_q && !long_q) // RULE18
    else $error("stop history wrong");
  AST_HIGH_ZERO: assert property (rd_i && addr_i == ADDR_STAT |=> rdata_o[13:11] == 3'h0) // RULE11
    else $error("unused status bits not zero");
endmodule
